// ### rtl/pdc_params.svh
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------
`define PDC_ADDR_W        14
`define PDC_DATA_W        16
`define PDC_CTRL_ADDR     14'h3fef
`define PDC_CTRL_RESET    16'h0000
`define PDC_OSC_OFF_BIT   15
`define PDC_DELAY_BIT     14
`define PDC_FORCE_BIT     13
`define PDC_CTX_BIT       12

// ----------------------------------------------------------------------
// Addresses and context values
// ----------------------------------------------------------------------
`define PDC_NMI_VECTOR    14'h002c
`define PDC_START_ADDR    14'h0000
`define PDC_SSTAT_INIT    8'h55

// ----------------------------------------------------------------------
// Timing counts in input clock cycles and counter widths
// ----------------------------------------------------------------------
`define PDC_TMR_W         13
`define PDC_WAKE_DELAY    13'h1000
`define PDC_RECOVERY      13'h0064
`define PDC_NEST_W        4

`endif

// ### rtl/pdc_pkg.sv
package pdc_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PDC_RUN,
        PDC_ENTER,
        PDC_DORMANT,
        PDC_WAKE
    } pdc_state_t;

endpackage

// ### rtl/pdc_wake_timer.sv
`timescale 1ns/10ps
`include "pdc_params.svh"

module pdc_wake_timer (
    input  wire logic                   mclk_i,
    input  wire logic                   reset_i,
    input  wire logic                   start_i,
    input  wire logic [`PDC_TMR_W-1:0]  load_i,
    output logic                        busy_o,
    output logic                        done_o
);

    logic [`PDC_TMR_W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Down counter with a one-cycle done pulse.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q  <= load_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_q <= `PDC_TMR_W'(1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - `PDC_TMR_W'(1);
                end
            end
        end
    end

endmodule

// ### rtl/pdc_top.sv
`timescale 1ns/10ps
`include "pdc_params.svh"

// Summary of operation
// - Pin falling edge or force-sleep bit write starts powerdown.
// - A request raises a non-maskable interrupt to vector 0x002C.
// - Interrupt never masked; new pulses during handler nest again.
// - Halt enters dormancy only while the request remains asserted.
// - Dormancy is reached one or two cycles after halt, by phase.
// - All register contents are retained while dormant.
// - Active outputs freeze at their last level while dormant.
// - Return-from-interrupt before halt abandons the powerdown.
// - Internal clocks are gated off while dormant.
// - Most input pins are ignored while dormant.
// - Control bits live in the register at address 0x3FEF.
// - Execution resumes after a fixed recovery window of 100 cycles.
// - A rising edge on the request pin ends dormancy.
// - Bit 14 set adds 4096 wake cycles; clear adds none.
// - Bit 12 set clears context, SSTAT 0x55, start at 0x0000.
// - Reset while dormant fully resets; wake delay is disregarded.

module pdc_top (
    input  wire logic                   mclk_i,
    input  wire logic                   reset_i,
    input  wire logic                   pwd_req_n_i,
    input  wire logic                   nmi_ack_i,
    input  wire logic                   halt_exec_i,
    input  wire logic                   rti_exec_i,
    input  wire logic [`PDC_ADDR_W-1:0] dm_addr_i,
    input  wire logic                   dm_wr_i,
    input  wire logic                   dm_rd_i,
    input  wire logic [`PDC_DATA_W-1:0] dm_wdata_i,
    output logic [`PDC_DATA_W-1:0]      dm_rdata_o,
    output logic                        nmi_req_o,
    output logic [`PDC_ADDR_W-1:0]      nmi_vector_o,
    output logic                        clk_en_o,
    output logic                        hold_outputs_o,
    output logic                        ignore_inputs_o,
    output logic                        dormant_o,
    output logic                        osc_off_o,
    output logic                        resume_o,
    output logic                        ctx_clear_o,
    output logic [`PDC_ADDR_W-1:0]      restart_addr_o,
    output logic [7:0]                  sstat_init_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pdc_pkg::pdc_state_t      state_q;
    logic [`PDC_DATA_W-1:0]   ctrl_q;
    logic                     pin_s1_q;
    logic                     pin_s2_q;
    logic                     pin_prev_q;
    logic                     pend_q;
    logic                     forced_q;
    logic [`PDC_NEST_W-1:0]   nest_q;
    logic                     phase_q;
    logic                     enter_wait_q;
    logic                     fall_evt;
    logic                     rise_evt;
    logic                     reg_hit;
    logic                     force_wr;
    logic                     req_active;
    logic                     halt_ok;
    logic                     tmr_start;
    logic [`PDC_TMR_W-1:0]    tmr_load;
    logic [`PDC_TMR_W-1:0]    wake_cnt_q;
    logic                     tmr_done;

    function automatic logic addr_hit(input logic [`PDC_ADDR_W-1:0] a);
        addr_hit = (a == `PDC_CTRL_ADDR);
    endfunction

    // ------------------------------------------------------------------
    // Request pin synchroniser and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_s1_q   <= 1'b1;
            pin_s2_q   <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_s1_q   <= pwd_req_n_i;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    assign fall_evt = pin_prev_q & ~pin_s2_q;
    assign rise_evt = ~pin_prev_q & pin_s2_q;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    assign reg_hit  = addr_hit(dm_addr_i);
    assign force_wr = dm_wr_i & reg_hit & dm_wdata_i[`PDC_FORCE_BIT] &
                      (state_q == pdc_pkg::PDC_RUN);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_q <= `PDC_CTRL_RESET;
        end else if (dm_wr_i && reg_hit && state_q == pdc_pkg::PDC_RUN) begin
            ctrl_q <= dm_wdata_i;
            ctrl_q[`PDC_FORCE_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dm_rdata_o <= '0;
        end else if (dm_rd_i && reg_hit) begin
            dm_rdata_o <= ctrl_q;
        end else begin
            dm_rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Pending interrupt, force flag and handler nesting
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pend_q <= 1'b0;
        end else if ((fall_evt || force_wr) &&
                     state_q == pdc_pkg::PDC_RUN) begin
            pend_q <= 1'b1;
        end else if (nmi_ack_i) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            nmi_req_o    <= 1'b0;
            nmi_vector_o <= `PDC_NMI_VECTOR;
        end else begin
            nmi_req_o    <= pend_q & ~nmi_ack_i;
            nmi_vector_o <= `PDC_NMI_VECTOR;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            nest_q <= '0;
        end else if (tmr_done && ctrl_q[`PDC_CTX_BIT]) begin
            nest_q <= '0;
        end else if (nmi_ack_i && !rti_exec_i) begin
            nest_q <= nest_q + `PDC_NEST_W'(1);
        end else if (rti_exec_i && !nmi_ack_i && nest_q != '0) begin
            nest_q <= nest_q - `PDC_NEST_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            forced_q <= 1'b0;
        end else if (force_wr) begin
            forced_q <= 1'b1;
        end else if (rti_exec_i || state_q == pdc_pkg::PDC_DORMANT) begin
            forced_q <= 1'b0;
        end
    end

    assign req_active = ~pin_s2_q | forced_q;
    assign halt_ok    = halt_exec_i & (nest_q != '0) & req_active;

    // ------------------------------------------------------------------
    // Internal clock phase
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // ------------------------------------------------------------------
    // Powerdown sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q      <= pdc_pkg::PDC_RUN;
            enter_wait_q <= 1'b0;
        end else begin
            case (state_q)
                pdc_pkg::PDC_RUN: begin
                    if (halt_ok) begin
                        state_q      <= pdc_pkg::PDC_ENTER;
                        enter_wait_q <= phase_q;
                    end
                end
                pdc_pkg::PDC_ENTER: begin
                    if (enter_wait_q) begin
                        enter_wait_q <= 1'b0;
                    end else begin
                        state_q <= pdc_pkg::PDC_DORMANT;
                    end
                end
                pdc_pkg::PDC_DORMANT: begin
                    if (rise_evt) begin
                        state_q <= pdc_pkg::PDC_WAKE;
                    end
                end
                pdc_pkg::PDC_WAKE: begin
                    if (tmr_done) begin
                        state_q <= pdc_pkg::PDC_RUN;
                    end
                end
                default: begin
                    state_q <= pdc_pkg::PDC_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wake timing
    // ------------------------------------------------------------------
    assign tmr_start = (state_q == pdc_pkg::PDC_DORMANT) & rise_evt;
    assign tmr_load  = ctrl_q[`PDC_DELAY_BIT] ?
                       `PDC_WAKE_DELAY + `PDC_RECOVERY :
                       `PDC_RECOVERY;

    pdc_wake_timer u_timer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .start_i (tmr_start),
        .load_i  (tmr_load),
        .busy_o  (),
        .done_o  (tmr_done)
    );

    // ------------------------------------------------------------------
    // Wake length counter
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i || tmr_start) begin
            wake_cnt_q <= '0;
        end else if (state_q == pdc_pkg::PDC_WAKE) begin
            wake_cnt_q <= wake_cnt_q + `PDC_TMR_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Clock gating, output hold and input ignore
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            clk_en_o        <= 1'b1;
            hold_outputs_o  <= 1'b0;
            ignore_inputs_o <= 1'b0;
            dormant_o       <= 1'b0;
            osc_off_o       <= 1'b0;
        end else begin
            clk_en_o        <= clk_en_o_next();
            hold_outputs_o  <= ~clk_en_o_next();
            ignore_inputs_o <= ~clk_en_o_next();
            dormant_o       <= ~clk_en_o_next();
            osc_off_o       <= ctrl_q[`PDC_OSC_OFF_BIT] &
                               ~clk_en_o_next();
        end
    end

    function automatic logic clk_en_o_next();
        clk_en_o_next = ~((state_q == pdc_pkg::PDC_ENTER && !enter_wait_q) ||
                          (state_q == pdc_pkg::PDC_DORMANT) ||
                          (state_q == pdc_pkg::PDC_WAKE && !tmr_done));
    endfunction

    // ------------------------------------------------------------------
    // Resume and context clear
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            resume_o       <= 1'b0;
            ctx_clear_o    <= 1'b0;
            restart_addr_o <= `PDC_START_ADDR;
            sstat_init_o   <= `PDC_SSTAT_INIT;
        end else begin
            resume_o       <= tmr_done;
            ctx_clear_o    <= tmr_done & ctrl_q[`PDC_CTX_BIT];
            restart_addr_o <= `PDC_START_ADDR;
            sstat_init_o   <= `PDC_SSTAT_INIT;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    a_fall_to_nmi: assert property (
        (fall_evt && state_q == pdc_pkg::PDC_RUN && !nmi_ack_i)
        ##1 !nmi_ack_i |=> nmi_req_o)
        else $error("falling edge did not raise the interrupt");

    a_force_to_nmi: assert property (
        force_wr && state_q == pdc_pkg::PDC_RUN ##1 !nmi_ack_i
        |=> nmi_req_o)
        else $error("force bit did not raise the interrupt");

    a_vector_fixed: assert property (
        nmi_req_o |-> nmi_vector_o == 14'h002c)
        else $error("interrupt vector wrong");

    a_nest_count: assert property (
        nmi_ack_i && !rti_exec_i && !tmr_done && nest_q != 4'hf
        |=> nest_q == $past(nest_q) + 4'h1)
        else $error("nested interrupt not counted");

    a_halt_needs_req: assert property (
        state_q == pdc_pkg::PDC_RUN ##1 state_q == pdc_pkg::PDC_ENTER
        |-> $past(req_active) && $past(nest_q) != '0)
        else $error("dormancy entered without request");

    a_enter_time: assert property (
        state_q == pdc_pkg::PDC_RUN && halt_ok
        |-> ##[2:3] state_q == pdc_pkg::PDC_DORMANT)
        else $error("dormancy not reached in one or two cycles");

    a_ctrl_retained: assert property (
        state_q == pdc_pkg::PDC_DORMANT |=> $stable(ctrl_q))
        else $error("control register lost while dormant");

    a_gated_dormant: assert property (
        $past(state_q) == pdc_pkg::PDC_DORMANT
        |-> !clk_en_o && hold_outputs_o && ignore_inputs_o)
        else $error("clocks or outputs not frozen while dormant");

    a_rti_abandons: assert property (
        rti_exec_i && nest_q == 4'h1 && !nmi_ack_i && !halt_exec_i &&
        state_q == pdc_pkg::PDC_RUN |=> state_q == pdc_pkg::PDC_RUN)
        else $error("return did not abandon powerdown");

    a_wake_nodelay: assert property (
        tmr_start && !ctrl_q[`PDC_DELAY_BIT]
        |-> ##[100:102] resume_o)
        else $error("wake without delay took wrong time");

    a_wake_delay: assert property (
        resume_o && ctrl_q[`PDC_DELAY_BIT] |->
        wake_cnt_q == `PDC_WAKE_DELAY + `PDC_RECOVERY + `PDC_TMR_W'(1))
        else $error("wake delay not inserted");

    a_ctx_clear: assert property (
        tmr_done && ctrl_q[`PDC_CTX_BIT] |=> ctx_clear_o &&
        restart_addr_o == 14'h0000 && sstat_init_o == 8'h55)
        else $error("context clear not applied on wake");

    c_pin_cycle: cover property (
        state_q == pdc_pkg::PDC_DORMANT ##[1:200] resume_o);
    c_force_entry: cover property (
        force_wr ##[1:20] state_q == pdc_pkg::PDC_DORMANT);
    c_nested: cover property (nest_q == 4'h2);
    c_abandon: cover property (
        nest_q == 4'h1 && rti_exec_i && state_q == pdc_pkg::PDC_RUN);

endmodule

// ### sim/pdc_req_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Request source and core acknowledge model
// ----------------------------------------------------------------------
module pdc_req_model (
    input  wire logic mclk_i,
    input  wire logic pin_cmd_i,
    input  wire logic slow_i,
    input  wire logic nmi_req_i,
    output logic      pwd_req_n_o,
    output logic      nmi_ack_o
);
    logic [3:0] wait_q;

    // The pin moves only when commanded, so it never pulses unasked.
    assign pwd_req_n_o = pin_cmd_i;

    initial begin
        nmi_ack_o = 1'b0;
        wait_q    = 4'h0;
    end

    // The core takes the interrupt promptly or five cycles late.
    always @(posedge mclk_i) begin
        if (nmi_ack_o) begin
            nmi_ack_o <= 1'b0;
            wait_q    <= 4'h0;
        end else if (nmi_req_i && wait_q >= (slow_i ? 4'h5 : 4'h0)) begin
            nmi_ack_o <= 1'b1;
        end else if (nmi_req_i) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ### sim/test_pdc_top.sv
`timescale 1ns/10ps
`include "pdc_params.svh"

module test_pdc_top;
    localparam logic [15:0] FORCE    = 16'h0001 << `PDC_FORCE_BIT;
    localparam logic [15:0] MODES[4] = '{16'h4000, 16'h8000, 16'h1000,
                                         16'hd000};
    logic        mclk_i;
    logic        reset_i;
    logic        pin;
    logic        pwd_n;
    logic        slow;
    logic        nmi_ack;
    logic        halt;
    logic        rti;
    logic [13:0] addr;
    logic [13:0] oth;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        nmi_req;
    logic [13:0] vec;
    logic        clk_en;
    logic        hold;
    logic        ign;
    logic        dormant;
    logic        osc;
    logic        resume;
    logic        ctx;
    logic [13:0] raddr;
    logic [7:0]  sstat;
    logic [31:0] seed;
    logic [15:0] rv;
    logic [15:0] cfg;
    int          n_errors;
    int          check_count;
    int          n_acks;
    int          n;

    pdc_top u_pdc_top (
        .mclk_i(mclk_i), .reset_i(reset_i), .pwd_req_n_i(pwd_n),
        .nmi_ack_i(nmi_ack), .halt_exec_i(halt), .rti_exec_i(rti),
        .dm_addr_i(addr), .dm_wr_i(wr), .dm_rd_i(rd), .dm_wdata_i(wdata),
        .dm_rdata_o(rdata), .nmi_req_o(nmi_req), .nmi_vector_o(vec),
        .clk_en_o(clk_en), .hold_outputs_o(hold), .ignore_inputs_o(ign),
        .dormant_o(dormant), .osc_off_o(osc), .resume_o(resume),
        .ctx_clear_o(ctx), .restart_addr_o(raddr), .sstat_init_o(sstat)
    );

    pdc_req_model u_pdc_req_model (
        .mclk_i(mclk_i), .pin_cmd_i(pin), .slow_i(slow),
        .nmi_req_i(nmi_req), .pwd_req_n_o(pwd_n), .nmi_ack_o(nmi_ack)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    initial begin
        #150000;
        n_errors++;
        tally_and_finish();
    end

    always @(posedge mclk_i) begin
        if (nmi_ack === 1'b1) n_acks++;
    end

    // ------------------------------------------------------------------
    // Expectations and helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] reg_expect(input logic [15:0] w);
        return w & ~FORCE;
    endfunction

    function automatic int wake_lo(input logic [15:0] c);
        return c[14] ? 4196 : 100;
    endfunction

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h to %h",
                     $time, got, lo, hi);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge mclk_i);
    endtask

    task automatic reg_write(input logic [13:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask

    task automatic reg_read(input logic [13:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        addr = a;
        rd   = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
        d  = rdata;
    endtask

    task automatic pulse(input logic is_rti);
        @(negedge mclk_i);
        if (is_rti) rti = 1'b1; else halt = 1'b1;
        @(negedge mclk_i);
        rti  = 1'b0;
        halt = 1'b0;
    endtask

    task automatic wait_on(input int which, input int lim, output int k);
        logic s;
        k = 0;
        s = 1'b0;
        while (s !== 1'b1 && k < lim) begin
            @(negedge mclk_i);
            k++;
            case (which)
                0: s = nmi_req;
                1: s = dormant;
                default: s = resume;
            endcase
        end
    endtask

    task automatic enter_dormant(input logic by_pin, input logic [15:0] c);
        int k;
        reg_write(`PDC_CTRL_ADDR, by_pin ? c : c | FORCE);
        pin = !by_pin;
        wait_on(0, 20, k);
        check_range(k, 1, 8);
        check_word({2'b00, vec}, 16'h002c);
        cycles(8);
        pulse(1'b0);
        wait_on(1, 4, k);
        check_range(k, 1, 2);
        check_word({12'h000, clk_en, hold, ign, osc}, {15'h0000, c[15]} | 16'h0006);
        reg_write(`PDC_CTRL_ADDR, 16'h0000);
    endtask

    task automatic wake(input logic [15:0] c);
        int k;
        pin = 1'b0;
        cycles(4);
        pin = 1'b1;
        wait_on(2, 5000, k);
        check_range(k, wake_lo(c), wake_lo(c) + 300);
        check_word({13'h0000, ctx, clk_en, dormant}, {13'h0000, c[12], 2'b10});
        if (c[12]) check_word({2'b00, raddr}, 16'h0000);
        if (c[12]) check_word({8'h00, sstat}, 16'h0055);
        cycles(6);
        check_word({15'h0000, nmi_req}, 16'h0000);
        if (!c[12]) pulse(1'b1);
        reg_read(`PDC_CTRL_ADDR, rv);
        check_word(rv, reg_expect(c));
    endtask

    task automatic test_end(input string name);
        $display("test %0s ended, mismatches %0d", name, n_errors);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        reset_i     = 1'b1;
        pin         = 1'b1;
        slow        = 1'b0;
        halt        = 1'b0;
        rti         = 1'b0;
        addr        = 14'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        wdata       = 16'h0000;
        n_errors    = 0;
        check_count = 0;
        n_acks      = 0;
        seed        = 32'h0000_8260;
        cycles(12);
        reset_i = 1'b0;
        reg_read(`PDC_CTRL_ADDR, rv);
        check_word(rv, 16'h0000);
        check_word({12'h000, nmi_req, clk_en, dormant, hold}, 16'h0004);
        test_end("reset");
        repeat (6) begin
            seed = xorshift(seed);
            cfg  = seed[15:0] & ~FORCE;
            reg_write(`PDC_CTRL_ADDR, cfg);
            oth = seed[29:16] == `PDC_CTRL_ADDR ? 14'h0000 : seed[29:16];
            reg_write(oth, ~cfg & ~FORCE);
            reg_read(oth, rv);
            check_word(rv, 16'h0000);
            reg_read(`PDC_CTRL_ADDR, rv);
            check_word(rv, cfg);
        end
        test_end("registers");
        reg_write(`PDC_CTRL_ADDR, 16'h0000);
        pulse(1'b0);
        cycles(4);
        check_word({15'h0000, dormant}, 16'h0000);
        pin = 1'b0;
        wait_on(0, 20, n);
        check_range(n, 1, 8);
        cycles(8);
        pulse(1'b1);
        pulse(1'b0);
        cycles(4);
        check_word({15'h0000, dormant}, 16'h0000);
        pin = 1'b1;
        cycles(6);
        test_end("abandon");
        n_acks = 0;
        pin    = 1'b0;
        wait_on(0, 20, n);
        cycles(8);
        pin = 1'b1;
        cycles(4);
        pin = 1'b0;
        wait_on(0, 20, n);
        cycles(8);
        check_range(n_acks, 2, 2);
        pulse(1'b1);
        pulse(1'b1);
        pin = 1'b1;
        cycles(6);
        test_end("nesting");
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            slow = seed[20];
            cfg  = MODES[i] | (seed[15:0] & 16'h0fff);
            enter_dormant(!i[0], cfg);
            wake(cfg);
            test_end("dormant cycle");
        end
        enter_dormant(1'b1, 16'h4000);
        reset_i = 1'b1;
        pin     = 1'b1;
        cycles(2000);
        reset_i = 1'b0;
        check_word({12'h000, dormant, clk_en, nmi_req, hold}, 16'h0004);
        wait_on(2, 200, n);
        check_range(n, 200, 200);
        reg_read(`PDC_CTRL_ADDR, rv);
        check_word(rv, 16'h0000);
        test_end("reset while dormant");
        tally_and_finish();
    end
endmodule
